// ---- logic/gsm_gate_mux.v ----
// stream gate substitution mux with a registered skid slice
`timescale 1ns/1ps
`default_nettype none
`include "gsm_map.vh"

module gsm_gate_mux #(
  parameter NUM_BYTES = `GSM_NUM_BYTES,
  parameter NUM_GATE_BITS = `GSM_NUM_GATE_BITS,
  parameter TS_W = `GSM_TS_W,
  parameter INFO_W = `GSM_INFO_W
) (
  // clock and reset
  input wire mclk,
  input wire reset,
  // gate control
  input wire [`GSM_SEL_W-1:0] gateSel,
  input wire [NUM_GATE_BITS-1:0] userGate,
  // stream slave
  input wire s_axis_tvalid,
  output wire s_axis_tready,
  input wire [NUM_BYTES*8-1:0] s_axis_tdata,
  input wire s_axis_tlast,
  input wire [TS_W-1:0] s_axis_timestamp,
  input wire [NUM_GATE_BITS-1:0] s_axis_gate,
  input wire s_axis_sync,
  input wire s_axis_pulsePerSecondEvent,
  input wire [INFO_W-1:0] s_axis_info,
  // stream master
  output wire m_axis_tvalid,
  input wire m_axis_tready,
  output wire [NUM_BYTES*8-1:0] m_axis_tdata,
  output wire m_axis_tlast,
  output wire [TS_W-1:0] m_axis_timestamp,
  output wire [NUM_GATE_BITS-1:0] m_axis_gate,
  output wire m_axis_sync,
  output wire m_axis_pulsePerSecondEvent,
  output wire [INFO_W-1:0] m_axis_info,
  // status
  output wire [`GSM_SEL_W-1:0] gateSelApplied,
  output wire paramError
);

  // ----------------------------------------------------------------
  // parameter legality
  // ----------------------------------------------------------------
  localparam BYTES_OK = (NUM_BYTES == 1) || (NUM_BYTES == 2) ||
    (NUM_BYTES == 3) || (NUM_BYTES == 4) || (NUM_BYTES == 6) ||
    (NUM_BYTES == 8);
  localparam GATES_OK = (NUM_GATE_BITS == 1) || (NUM_GATE_BITS == 2) ||
    (NUM_GATE_BITS == 4) || (NUM_GATE_BITS == 8);
  localparam [0:0] PARAM_BAD = (BYTES_OK && GATES_OK) ? 1'b0 : 1'b1;

  // payload layout, gate bits at the bottom
  localparam DATA_W = NUM_BYTES * 8;
  localparam PAY_W = DATA_W + TS_W + INFO_W + 3 + NUM_GATE_BITS;

  // field positions inside the payload word
  localparam PPS_POS = NUM_GATE_BITS;
  localparam SYNC_POS = NUM_GATE_BITS + 1;
  localparam LAST_POS = NUM_GATE_BITS + 2;
  localparam INFO_LO = NUM_GATE_BITS + 3;
  localparam TS_LO = INFO_LO + INFO_W;
  localparam DATA_LO = TS_LO + TS_W;

  // ----------------------------------------------------------------
  // select retiming
  // ----------------------------------------------------------------
  wire [`GSM_SEL_W-1:0] selSync;

  // two stages, reset to pass-through
  gsm_sync #(
    .WIDTH(`GSM_SEL_W),
    .STAGES(`GSM_SYNC_STAGES),
    .RESET_VAL(`GSM_SEL_RESET)
  ) uSelSync (
    .mclk(mclk),
    .reset(reset),
    .levelIn(gateSel),
    .levelOut(selSync)
  );

  // ----------------------------------------------------------------
  // gate selector
  // ----------------------------------------------------------------
  reg [NUM_GATE_BITS-1:0] gateNew;

  always @* begin
    case (selSync)
      `GSM_SEL_PASS: begin
        gateNew = s_axis_gate;
      end
      `GSM_SEL_USER: begin
        gateNew = userGate;
      end
      `GSM_SEL_AND: begin
        gateNew = userGate & s_axis_gate;
      end
      `GSM_SEL_SPARE: begin
        gateNew = s_axis_gate;
      end
      default: begin
        gateNew = s_axis_gate;
      end
    endcase
  end

  // other fields untouched, only gate slot substituted
  wire [PAY_W-1:0] payIn;
  assign payIn = {s_axis_tdata, s_axis_timestamp, s_axis_info,
    s_axis_tlast, s_axis_sync, s_axis_pulsePerSecondEvent,
    gateNew};

  // ----------------------------------------------------------------
  // registered skid slice
  // ----------------------------------------------------------------
  reg outValid_r;
  reg outValid_nxt;
  reg [PAY_W-1:0] outPay_r;
  reg [PAY_W-1:0] outPay_nxt;
  reg skidValid_r;
  reg skidValid_nxt;
  reg [PAY_W-1:0] skidPay_r;
  reg [PAY_W-1:0] skidPay_nxt;
  reg inReady_r;
  reg inReady_nxt;
  reg [`GSM_SEL_W-1:0] selApplied_r;
  reg paramError_r;

  wire inTake;
  wire outFree;
  assign inTake = s_axis_tvalid & inReady_r;
  assign outFree = ~outValid_r | m_axis_tready;

  always @* begin
    outValid_nxt = outValid_r;
    outPay_nxt = outPay_r;
    skidValid_nxt = skidValid_r;
    skidPay_nxt = skidPay_r;
    if (outFree) begin
      if (skidValid_r) begin
        // drain the held beat first to keep order
        outValid_nxt = 1'b1;
        outPay_nxt = skidPay_r;
        skidValid_nxt = 1'b0;
        if (inTake) begin
          skidValid_nxt = 1'b1;
          skidPay_nxt = payIn;
        end
      end else begin
        outValid_nxt = inTake;
        if (inTake) begin
          outPay_nxt = payIn;
        end
      end
    end else if (inTake) begin
      skidValid_nxt = 1'b1;
      skidPay_nxt = payIn;
    end
    inReady_nxt = ~skidValid_nxt;
  end

  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      outValid_r <= 1'b0;
      outPay_r <= {PAY_W{1'b0}};
      skidValid_r <= 1'b0;
      skidPay_r <= {PAY_W{1'b0}};
      inReady_r <= 1'b0;
    end else begin
      outValid_r <= outValid_nxt;
      outPay_r <= outPay_nxt;
      skidValid_r <= skidValid_nxt;
      skidPay_r <= skidPay_nxt;
      inReady_r <= inReady_nxt;
    end
  end

  // ----------------------------------------------------------------
  // status registers
  // ----------------------------------------------------------------
  // reports the select the gate selector used on the previous cycle, updated every cycle
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      selApplied_r <= `GSM_SEL_RESET;
      paramError_r <= 1'b0;
    end else begin
      selApplied_r <= selSync;
      paramError_r <= PARAM_BAD;
    end
  end

  // ----------------------------------------------------------------
  // output unpacking
  // ----------------------------------------------------------------
  assign s_axis_tready = inReady_r;
  assign m_axis_tvalid = outValid_r;
  assign m_axis_gate = outPay_r[NUM_GATE_BITS-1:0];
  assign m_axis_pulsePerSecondEvent = outPay_r[PPS_POS];
  assign m_axis_sync = outPay_r[SYNC_POS];
  assign m_axis_tlast = outPay_r[LAST_POS];
  assign m_axis_info = outPay_r[TS_LO-1:INFO_LO];
  assign m_axis_timestamp = outPay_r[DATA_LO-1:TS_LO];
  assign m_axis_tdata = outPay_r[PAY_W-1:DATA_LO];
  assign gateSelApplied = selApplied_r;
  assign paramError = paramError_r;

endmodule

`default_nettype wire

// ---- logic/gsm_map.vh ----
// constants for the stream gate substitution mux
`ifndef GSM_MAP_VH
`define GSM_MAP_VH

// gate select field
`define GSM_SEL_W 2
`define GSM_SEL_PASS 2'h0
`define GSM_SEL_USER 2'h1
`define GSM_SEL_AND 2'h2
`define GSM_SEL_SPARE 2'h3
`define GSM_SEL_RESET 2'h0

// synchroniser depth
`define GSM_SYNC_STAGES 2

// default field widths
`define GSM_NUM_BYTES 4
`define GSM_NUM_GATE_BITS 1
`define GSM_TS_W 64
`define GSM_INFO_W 16

`endif

// ---- logic/gsm_sync.v ----
// multi-bit level synchroniser
`timescale 1ns/1ps
`default_nettype none

module gsm_sync #(
  parameter WIDTH = 2,
  parameter STAGES = 2,
  parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b0}}
) (
  // clock and reset
  input wire mclk,
  input wire reset,
  // level in and synchronised level out
  input wire [WIDTH-1:0] levelIn,
  output wire [WIDTH-1:0] levelOut
);

  reg [WIDTH*STAGES-1:0] chain_r;

  // first stage feeds only the second stage
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      chain_r <= {STAGES{RESET_VAL}};
    end else begin
      chain_r <= {chain_r[WIDTH*(STAGES-1)-1:0], levelIn};
    end
  end

  assign levelOut = chain_r[WIDTH*STAGES-1:WIDTH*(STAGES-1)];

endmodule

`default_nettype wire

// ---- test/gsm_chk.sv ----
// gate mux port checker
`timescale 1ns/1ps
`default_nettype none
module gsm_chk #(parameter NUM_BYTES = 4, parameter NUM_GATE_BITS = 1) (
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // gate control and status
  input wire logic [1:0] gateSel,
  input wire logic [1:0] gateSelApplied,
  input wire logic [NUM_GATE_BITS-1:0] userGate,
  // stream payload
  input wire logic [NUM_GATE_BITS-1:0] s_axis_gate,
  input wire logic [NUM_GATE_BITS-1:0] m_axis_gate,
  input wire logic [NUM_BYTES*8-1:0] s_axis_tdata,
  input wire logic [NUM_BYTES*8-1:0] m_axis_tdata,
  // stream handshakes
  input wire logic s_axis_tvalid,
  input wire logic s_axis_tready,
  input wire logic m_axis_tvalid,
  input wire logic m_axis_tready
);
  // beat taken straight into a free output slot
  wire tk;
  assign tk = s_axis_tvalid && s_axis_tready &&
    (!m_axis_tvalid || m_axis_tready);
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  chk_pass_gate:
    assert property (tk ##1 gateSelApplied[0] == gateSelApplied[1] |->
      m_axis_gate == $past(s_axis_gate)) else $error("gate not passed");
  chk_user_gate:
    assert property (tk ##1 gateSelApplied == 2'h1 |->
      m_axis_gate == $past(userGate)) else $error("user gate wrong");
  chk_and_gate:
    assert property (tk ##1 gateSelApplied == 2'h2 |-> m_axis_gate ==
      ($past(userGate) & $past(s_axis_gate))) else $error("and gate wrong");
  chk_data_pass:
    assert property (tk |=> m_axis_tvalid &&
      m_axis_tdata == $past(s_axis_tdata)) else $error("data altered");
  chk_out_hold:
    assert property (m_axis_tvalid && !m_axis_tready |=> m_axis_tvalid &&
      $stable(m_axis_tdata) && $stable(m_axis_gate))
      else $error("beat dropped");
  chk_in_refuse:
    assert property (!s_axis_tready && !$past(reset) |-> m_axis_tvalid)
      else $error("refused while idle");
  chk_sel_settle:
    assert property ($stable(gateSel)[*3] |-> gateSelApplied == gateSel)
      else $error("select not applied");
  chk_sel_retime:
    assert property ($changed(gateSel) |-> ##2
      gateSelApplied == $past(gateSel, 3)) else $error("select too early");
endmodule
bind gsm_gate_mux gsm_chk #(.NUM_BYTES(NUM_BYTES),
  .NUM_GATE_BITS(NUM_GATE_BITS)) chk (
  .mclk(mclk),
  .reset(reset),
  .gateSel(gateSel),
  .gateSelApplied(gateSelApplied),
  .userGate(userGate),
  .s_axis_gate(s_axis_gate),
  .m_axis_gate(m_axis_gate),
  .s_axis_tdata(s_axis_tdata),
  .m_axis_tdata(m_axis_tdata),
  .s_axis_tvalid(s_axis_tvalid),
  .s_axis_tready(s_axis_tready),
  .m_axis_tvalid(m_axis_tvalid),
  .m_axis_tready(m_axis_tready)
);
`default_nettype wire

// ---- test/gsm_gate_mux_tb_top.sv ----
// testbench for the gate mux
`timescale 1ns/1ps
`default_nettype none
module gsm_gate_mux_tb_top;
  localparam G = 4;
  localparam W = 32 + 64 + 16 + G + 3;
  logic mclk = 0;
  logic reset = 1;
  logic [1:0] gateSel = 0;
  logic [1:0] stall = 0;
  logic [G-1:0] userGate = 0, s_axis_gate = 0;
  logic s_axis_tvalid = 0, s_axis_tlast = 0, s_axis_sync = 0;
  logic s_axis_pulsePerSecondEvent = 0;
  logic [31:0] s_axis_tdata = 0;
  logic [63:0] s_axis_timestamp = 0;
  logic [15:0] s_axis_info = 0;
  wire s_axis_tready, m_axis_tready, m_axis_tvalid, m_axis_tlast, m_axis_sync;
  wire m_axis_pulsePerSecondEvent, paramError;
  wire [31:0] m_axis_tdata;
  wire [63:0] m_axis_timestamp;
  wire [15:0] m_axis_info;
  wire [G-1:0] m_axis_gate;
  wire [1:0] gateSelApplied;
  wire [W-1:0] outBeat = {m_axis_tdata, m_axis_timestamp, m_axis_info,
    m_axis_gate, m_axis_tlast, m_axis_sync, m_axis_pulsePerSecondEvent};
  int error_cnt = 0, comparisons = 0, q1 = 0, q2 = 0, q3 = 0, got = 0;
  logic [W-1:0] expQ[$];
  gsm_gate_mux #(.NUM_GATE_BITS(G)) uut (
    .mclk(mclk),
    .reset(reset),
    .gateSel(gateSel),
    .userGate(userGate),
    .s_axis_tvalid(s_axis_tvalid),
    .s_axis_tready(s_axis_tready),
    .s_axis_tdata(s_axis_tdata),
    .s_axis_tlast(s_axis_tlast),
    .s_axis_timestamp(s_axis_timestamp),
    .s_axis_gate(s_axis_gate),
    .s_axis_sync(s_axis_sync),
    .s_axis_pulsePerSecondEvent(s_axis_pulsePerSecondEvent),
    .s_axis_info(s_axis_info),
    .m_axis_tvalid(m_axis_tvalid),
    .m_axis_tready(m_axis_tready),
    .m_axis_tdata(m_axis_tdata),
    .m_axis_tlast(m_axis_tlast),
    .m_axis_timestamp(m_axis_timestamp),
    .m_axis_gate(m_axis_gate),
    .m_axis_sync(m_axis_sync),
    .m_axis_pulsePerSecondEvent(m_axis_pulsePerSecondEvent),
    .m_axis_info(m_axis_info),
    .gateSelApplied(gateSelApplied),
    .paramError(paramError)
  );
  gsm_sink sink (.mclk(mclk), .stall(stall), .ready(m_axis_tready));
  initial forever #12.5 mclk = ~mclk;

  task check(input string nm, input logic [W-1:0] seen,
    input logic [W-1:0] ex);
    comparisons++;
    if (seen !== ex) begin
      error_cnt++;
      $display("[ERR] %s exp %h seen %h", nm, ex, seen);
    end
  endtask

  task results;
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // model: three-stage select pipeline, expected beats queued in order
  always @(negedge mclk) begin
    if (reset) begin
      q1 = 0;
      q2 = 0;
      q3 = 0;
    end else begin
      check("applied", W'(gateSelApplied), W'(q3));
      if (s_axis_tvalid && s_axis_tready)
        expQ.push_back({s_axis_tdata, s_axis_timestamp, s_axis_info,
          q2 == 1 ? userGate : q2 == 2 ? (userGate & s_axis_gate) : s_axis_gate,
          s_axis_tlast, s_axis_sync, s_axis_pulsePerSecondEvent});
      if (m_axis_tvalid && m_axis_tready) begin
        got++;
        check("beat", outBeat, expQ.pop_front());
      end
      q3 = q2;
      q2 = q1;
      q1 = gateSel;
    end
  end

  task send;
    s_axis_tvalid = 1;
    s_axis_tdata = $urandom;
    s_axis_timestamp = {$urandom, $urandom};
    s_axis_info = 16'($urandom);
    {userGate, s_axis_gate, s_axis_tlast, s_axis_sync,
      s_axis_pulsePerSecondEvent} = 11'($urandom);
    do @(negedge mclk); while (!s_axis_tready);
    @(posedge mclk);
    #1;
    if ($urandom % 4 == 0) begin
      s_axis_tvalid = 0;
      @(posedge mclk);
      #1;
    end
  endtask

  initial begin
    #100000;
    error_cnt++;
    results;
  end

  initial begin
    void'($urandom(32'h4a94ff78));
    repeat (8) @(posedge mclk);
    #1 reset = 0;
    for (int m = 0; m < 12; m++) begin
      gateSel = 2'(m % 4);
      stall = 2'(m / 4);
      repeat (16) send();
      $display("test mode %0d stall %0d done", m % 4, m / 4);
    end
    s_axis_tvalid = 0;
    stall = 0;
    repeat (20) @(posedge mclk);
    check("param", W'(paramError), W'(0));
    check("count", W'(got), W'(192));
    results;
  end
endmodule
`default_nettype wire

// ---- test/gsm_sink.sv ----
// downstream stream sink model
`timescale 1ns/1ps
`default_nettype none
module gsm_sink (
  // clock
  input wire logic mclk,
  // back-pressure level and ready out
  input wire logic [1:0] stall,
  output logic ready
);
  // accepts on every cycle at stall 0, else on a random share of cycles, fewer as stall grows
  always @(posedge mclk)
    ready <= #1 ($urandom % 4) >= stall;
endmodule
`default_nettype wire
